// >>> rtl/ppn_pkg.sv
// Package for the pattern next-data staging block: map, field layout, reset values
package ppn_pkg;

   // Register indices as printed; byte address on the bus is four times the index
   localparam logic [15:0] IDX_TRIG_SEL = 16'hFFA1;
   localparam logic [15:0] IDX_EN_HIGH = 16'hFFA2;
   localparam logic [15:0] IDX_EN_LOW = 16'hFFA3;
   localparam logic [15:0] IDX_NEXT_HIGH = 16'hFFA4;
   localparam logic [15:0] IDX_NEXT_LOW = 16'hFFA5;
   localparam logic [15:0] IDX_NEXT_G2 = 16'hFFA6;
   localparam logic [15:0] IDX_NEXT_G0 = 16'hFFA7;
   localparam logic [15:0] IDX_PORT_A = 16'hFFD3;
   localparam logic [15:0] IDX_PORT_B = 16'hFFD6;

   // Bus geometry
   localparam int ADR_W = 18;
   localparam int DAT_W = 32;
   localparam int REG_W = 8;

   // Reset values
   localparam logic [7:0] RST_NEXT = 8'h00;
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_TRIG_SEL = 8'hFF;
   localparam logic [7:0] RST_PORT = 8'h00;
   localparam logic [7:0] RESERVED_BYTE = 8'hFF;
   localparam logic [3:0] RESERVED_NIBBLE = 4'hF;

   // Trigger select field positions: two bits per group, group 0 lowest
   localparam int TSEL_G0_LSB = 0;
   localparam int TSEL_G1_LSB = 2;
   localparam int TSEL_G2_LSB = 4;
   localparam int TSEL_G3_LSB = 6;
   localparam int TSEL_W = 2;

   // Port B bit that carries pattern bit fourteen, which has no pin
   localparam int PB_NO_PIN_BIT = 6;

   // Decoded bus access, carried as one unit
   typedef struct packed {
      logic active;
      logic write;
      logic lane0;
      logic [15:0] index;
      logic [7:0] wdata;
   } ppn_access_t;

endpackage : ppn_pkg

// >>> rtl/ppn_top.sv
// Next-data staging, enable masks and port data for the 16-bit pattern output unit
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps

// Summary of operation
// - Low-pair staging byte copies into port A data on the selected compare match.
// - Shared trigger for groups 0/1: whole byte at FFA5, FFA7 reads all ones.
// - Split triggers: group 1 upper nibble at FFA5, group 0 lower nibble at FFA7.
// - Low-pair staging clears on reset and hardware standby, kept in software standby.
// - High-pair staging byte copies into port B data on the selected compare match.
// - Shared trigger for groups 2/3: whole byte at FFA4, FFA6 reads all ones.
// - Split triggers: group 3 upper nibble at FFA4, group 2 lower nibble at FFA6.
// - High-pair staging clears on reset and hardware standby, kept in software standby.
// - Low-pair enable bit one lets its staged bit reach port A; zero blocks.
// - High-pair enable bit one lets staged bits 15..8 reach port B; zero blocks.
// - Low-pair enable mask clears on reset and hardware standby, kept otherwise.
// - High-pair enable mask clears on reset and hardware standby, kept otherwise.
// - Pattern bit fourteen is staged internally but never driven to a pin.
// - Port data bits enabled for pattern output ignore software writes.
// - Each group has a two-bit trigger select, all reset to channel three.
module ppn_top
(
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic HW_STANDBY_I,
   input wire logic SW_STANDBY_I,
   input wire logic [3:0] CMP_MATCH_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [ppn_pkg::ADR_W-1:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [ppn_pkg::DAT_W-1:0] DAT_I,
   output logic [ppn_pkg::DAT_W-1:0] DAT_O,
   output logic ACK_O,
   output logic [7:0] PA_O,
   output logic [7:0] PB_O
);

   logic ack_ff;
   logic [ppn_pkg::DAT_W-1:0] rdat_ff;
   logic [7:0] next_low_ff;
   logic [7:0] next_high_ff;
   logic [7:0] en_low_ff;
   logic [7:0] en_high_ff;
   logic [7:0] trig_sel_ff;
   logic [7:0] port_a_ff;
   logic [7:0] port_b_ff;
   logic [3:0] grp_fire;
   logic low_shared;
   logic high_shared;
   logic word_ok;
   logic wr_go;
   ppn_pkg::ppn_access_t acc;
   logic [7:0] nxt_rdat;
   logic [7:0] nxt_port_a;
   logic [7:0] nxt_port_b;
   logic [15:0] fire_mask;

   // Decode the bus request; only whole-word aligned addresses are mapped
   always_comb
   begin
      acc.active = CYC_I & STB_I;
      acc.write = WE_I;
      acc.lane0 = SEL_I[0];
      acc.index = ADR_I[17:2];
      acc.wdata = DAT_I[7:0];
   end

   assign word_ok = (ADR_I[1:0] == 2'h0);
   // Writes land on the edge where the master samples the acknowledge
   assign wr_go = acc.active & ack_ff & acc.write & acc.lane0 & word_ok;

   // Groups sharing a trigger share one field value
   assign low_shared = (trig_sel_ff[ppn_pkg::TSEL_G0_LSB +: ppn_pkg::TSEL_W]
                        == trig_sel_ff[ppn_pkg::TSEL_G1_LSB +: ppn_pkg::TSEL_W]);
   assign high_shared = (trig_sel_ff[ppn_pkg::TSEL_G2_LSB +: ppn_pkg::TSEL_W]
                         == trig_sel_ff[ppn_pkg::TSEL_G3_LSB +: ppn_pkg::TSEL_W]);

   // Per-group strobe picked from the four timer channels
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_fire
         assign grp_fire[g] = CMP_MATCH_I[trig_sel_ff[g*2 +: 2]] & ~SW_STANDBY_I;
         assign fire_mask[g*4 +: 4] = {4{grp_fire[g]}};
      end
   endgenerate

   // Wishbone acknowledge: one wait state, dropped the cycle after it was given
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         ack_ff <= 1'b0;
      else
         ack_ff <= acc.active & ~ack_ff;
   end

   // Read mux; split layouts pad the unused nibble with ones
   always_comb
   begin
      nxt_rdat = 8'h00;
      if (word_ok)
      begin
         unique case (acc.index)
            ppn_pkg::IDX_TRIG_SEL: nxt_rdat = trig_sel_ff;
            ppn_pkg::IDX_EN_HIGH: nxt_rdat = en_high_ff;
            ppn_pkg::IDX_EN_LOW: nxt_rdat = en_low_ff;
            ppn_pkg::IDX_NEXT_HIGH: nxt_rdat = high_shared ? next_high_ff
                                     : {next_high_ff[7:4], ppn_pkg::RESERVED_NIBBLE};
            ppn_pkg::IDX_NEXT_LOW: nxt_rdat = low_shared ? next_low_ff
                                    : {next_low_ff[7:4], ppn_pkg::RESERVED_NIBBLE};
            ppn_pkg::IDX_NEXT_G2: nxt_rdat = high_shared ? ppn_pkg::RESERVED_BYTE
                                   : {ppn_pkg::RESERVED_NIBBLE, next_high_ff[3:0]};
            ppn_pkg::IDX_NEXT_G0: nxt_rdat = low_shared ? ppn_pkg::RESERVED_BYTE
                                   : {ppn_pkg::RESERVED_NIBBLE, next_low_ff[3:0]};
            ppn_pkg::IDX_PORT_A: nxt_rdat = port_a_ff;
            ppn_pkg::IDX_PORT_B: nxt_rdat = port_b_ff;
            default: nxt_rdat = 8'h00; // Unmapped reads answer zero
         endcase
      end
   end

   // Read data is captured with the acknowledge so it comes from a flip-flop
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         rdat_ff <= '0;
      else if (acc.active & ~ack_ff)
         rdat_ff <= {24'h000000, nxt_rdat};
   end

   // Trigger select register
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         trig_sel_ff <= ppn_pkg::RST_TRIG_SEL;
      else if (HW_STANDBY_I)
         trig_sel_ff <= ppn_pkg::RST_TRIG_SEL;
      else if (wr_go && acc.index == ppn_pkg::IDX_TRIG_SEL)
         trig_sel_ff <= acc.wdata;
   end

   // Low-pair staging; software standby simply does not touch it
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         next_low_ff <= ppn_pkg::RST_NEXT;
      else if (HW_STANDBY_I)
         next_low_ff <= ppn_pkg::RST_NEXT;
      else if (wr_go && acc.index == ppn_pkg::IDX_NEXT_LOW)
      begin
         if (low_shared)
            next_low_ff <= acc.wdata;
         else
            next_low_ff[7:4] <= acc.wdata[7:4];
      end
      else if (wr_go && acc.index == ppn_pkg::IDX_NEXT_G0 && !low_shared)
         next_low_ff[3:0] <= acc.wdata[3:0];
   end

   // High-pair staging; bit 6 holds pattern bit fourteen internally
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         next_high_ff <= ppn_pkg::RST_NEXT;
      else if (HW_STANDBY_I)
         next_high_ff <= ppn_pkg::RST_NEXT;
      else if (wr_go && acc.index == ppn_pkg::IDX_NEXT_HIGH)
      begin
         if (high_shared)
            next_high_ff <= acc.wdata;
         else
            next_high_ff[7:4] <= acc.wdata[7:4];
      end
      else if (wr_go && acc.index == ppn_pkg::IDX_NEXT_G2 && !high_shared)
         next_high_ff[3:0] <= acc.wdata[3:0];
   end

   // Enable masks
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         en_low_ff <= ppn_pkg::RST_ENABLE;
         en_high_ff <= ppn_pkg::RST_ENABLE;
      end
      else if (HW_STANDBY_I)
      begin
         en_low_ff <= ppn_pkg::RST_ENABLE;
         en_high_ff <= ppn_pkg::RST_ENABLE;
      end
      else if (wr_go)
      begin
         if (acc.index == ppn_pkg::IDX_EN_LOW)
            en_low_ff <= acc.wdata;
         if (acc.index == ppn_pkg::IDX_EN_HIGH)
            en_high_ff <= acc.wdata;
      end
   end

   // Next port data: software writes only reach bits not owned by pattern output,
   // so a transfer and a write never fight over the same bit
   always_comb
   begin
      nxt_port_a = port_a_ff;
      nxt_port_b = port_b_ff;
      if (wr_go && acc.index == ppn_pkg::IDX_PORT_A)
         nxt_port_a = (port_a_ff & en_low_ff) | (acc.wdata & ~en_low_ff);
      if (wr_go && acc.index == ppn_pkg::IDX_PORT_B)
         nxt_port_b = (port_b_ff & en_high_ff) | (acc.wdata & ~en_high_ff);
      // Staging values read here are pre-write, as the flops update afterwards
      nxt_port_a = (nxt_port_a & ~(en_low_ff & fire_mask[7:0]))
                   | (next_low_ff & en_low_ff & fire_mask[7:0]);
      nxt_port_b = (nxt_port_b & ~(en_high_ff & fire_mask[15:8]))
                   | (next_high_ff & en_high_ff & fire_mask[15:8]);
   end

   // Port data registers
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         port_a_ff <= ppn_pkg::RST_PORT;
         port_b_ff <= ppn_pkg::RST_PORT;
      end
      else if (HW_STANDBY_I)
      begin
         port_a_ff <= ppn_pkg::RST_PORT;
         port_b_ff <= ppn_pkg::RST_PORT;
      end
      else
      begin
         port_a_ff <= nxt_port_a;
         port_b_ff <= nxt_port_b;
      end
   end

   assign ACK_O = ack_ff;
   assign DAT_O = rdat_ff;
   assign PA_O = port_a_ff;
   // No pin exists for pattern bit fourteen, so it is forced low at the boundary
   always_comb
   begin
      PB_O = port_b_ff;
      PB_O[ppn_pkg::PB_NO_PIN_BIT] = 1'b0;
   end

endmodule : ppn_top

// >>> bench/ppn_sva.sv
// Port assertions for the pattern staging block
`timescale 1ns/100ps
module ppn_sva
(
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic HW_STANDBY_I,
   input wire logic SW_STANDBY_I,
   input wire logic [3:0] CMP_MATCH_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [ppn_pkg::ADR_W-1:0] ADR_I,
   input wire logic [ppn_pkg::DAT_W-1:0] DAT_O,
   input wire logic ACK_O,
   input wire logic [7:0] PA_O,
   input wire logic [7:0] PB_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   // A fresh request, then one wait state and a single-cycle answer
   sequence s_req;
      CYC_I && STB_I && !ACK_O;
   endsequence
   sequence s_ans;
      ACK_O ##1 !ACK_O;
   endsequence
   a_ack_one_wait: assert property (s_req |=> s_ans)
      else $error("ack not one cycle after request");
   a_upper_zero: assert property (ACK_O |-> DAT_O[31:8] == 24'h000000)
      else $error("read data above byte lane nonzero");
   a_no_pin_14: assert property (PB_O[ppn_pkg::PB_NO_PIN_BIT] == 1'b0)
      else $error("pattern bit fourteen reached a pin");
   // Outputs move only on a strobe, a bus write or a standby clear
   a_ports_idle: assert property (!(|CMP_MATCH_I) && !ACK_O && !HW_STANDBY_I |=> $stable({PA_O, PB_O}))
      else $error("port data moved without a cause");
   a_sw_keep: assert property (SW_STANDBY_I && !HW_STANDBY_I && !ACK_O |=> $stable({PA_O, PB_O}))
      else $error("transfer during software standby");
   a_hw_clear: assert property (HW_STANDBY_I |=> PA_O == 8'h00 && PB_O == 8'h00)
      else $error("ports not cleared by hardware standby");
   // Readback is only compared when the port did not move under the read
   a_pa_readback: assert property (ACK_O && !WE_I && ADR_I[17:2] == ppn_pkg::IDX_PORT_A && $stable(PA_O)
      |-> DAT_O[7:0] == PA_O)
      else $error("port A readback differs from pins");
   a_pb_readback: assert property (ACK_O && !WE_I && ADR_I[17:2] == ppn_pkg::IDX_PORT_B && $stable(PB_O)
      |-> DAT_O[7:0] == PB_O)
      else $error("port B readback differs from pins");
endmodule : ppn_sva
bind ppn_top ppn_sva chk_u (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .HW_STANDBY_I(HW_STANDBY_I),
   .SW_STANDBY_I(SW_STANDBY_I), .CMP_MATCH_I(CMP_MATCH_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
   .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .PA_O(PA_O), .PB_O(PB_O));

// >>> bench/ppn_cmp_src.sv
// Compare-match source standing in for the timer channels
`timescale 1ns/100ps
module ppn_cmp_src
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] fire_i,
   output logic [3:0] cmp_o
);
   // Registered so a strobe is a clean one-cycle pulse, as a timer gives
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cmp_o <= 4'h0;
      else
         cmp_o <= fire_i;
   end
endmodule : ppn_cmp_src

// >>> bench/ppn_top_tb.sv
// Self-checking bench for the pattern staging block
`timescale 1ns/100ps
module ppn_top_tb;
   logic clk = 1'b0, rst_n = 1'b0, hw = 1'b0, sw = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [3:0] fire = 4'h0, sel = 4'h0, cmp;
   logic [17:0] adr = 18'h00000;
   logic [31:0] dat_i = 32'h00000000, dat_o;
   logic [7:0] pa, pb;
   int n_mismatch = 0;
   int compares = 0;
   always #50 clk = ~clk;
   // Pattern pins are taken as outputs, as software sets their direction bits
   ppn_cmp_src src_u (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .cmp_o(cmp));
   ppn_top dut_u (.MCLK_I(clk), .RST_N_I(rst_n), .HW_STANDBY_I(hw), .SW_STANDBY_I(sw), .CMP_MATCH_I(cmp),
      .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o),
      .ACK_O(ack), .PA_O(pa), .PB_O(pb));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // One classic cycle; f rides along so a strobe can meet the write edge
   task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] d, input logic [3:0] f,
      output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, sel, adr, dat_i, fire} <= {2'b11, w, 4'h1, idx, 2'b00, 24'h000000, d, f};
      do
      begin
         @(posedge clk);
         fire <= 4'h0;
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = dat_o[7:0];
      {cyc, stb} <= 2'b00;
      if (n >= 20)
      begin
         n_mismatch++;
         $display("[ERR] %0t bus request never acknowledged", $time);
      end
   endtask : bus
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(idx, 1'b1, d, 4'h0, q);
   endtask : wr
   task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(idx, 1'b0, 8'h00, 4'h0, q);
      chk(q, exp);
   endtask : rd
   // Partner answers one cycle late, the port one cycle after that
   task automatic pulse(input logic [3:0] ch);
      @(posedge clk);
      fire <= ch;
      @(posedge clk);
      fire <= 4'h0;
      @(posedge clk);
      #1;
   endtask : pulse
   // Reset map: shared triggers leave the split addresses fully reserved
   task automatic t_reset;
      rd(ppn_pkg::IDX_TRIG_SEL, 8'hFF);
      rd(ppn_pkg::IDX_NEXT_LOW, 8'h00);
      rd(ppn_pkg::IDX_NEXT_HIGH, 8'h00);
      rd(ppn_pkg::IDX_EN_LOW, 8'h00);
      rd(ppn_pkg::IDX_EN_HIGH, 8'h00);
      wr(ppn_pkg::IDX_NEXT_G0, 8'h00);
      rd(ppn_pkg::IDX_NEXT_G0, 8'hFF);
      wr(ppn_pkg::IDX_NEXT_G2, 8'h00);
      rd(ppn_pkg::IDX_NEXT_G2, 8'hFF);
      rd(16'h0000, 8'h00);
   endtask : t_reset
   // Shared trigger, full masks, then a partial low mask and a cleared high mask; enabled port bits refuse writes
   task automatic t_shared;
      wr(ppn_pkg::IDX_NEXT_LOW, 8'hA5);
      wr(ppn_pkg::IDX_EN_LOW, 8'hFF);
      wr(ppn_pkg::IDX_NEXT_HIGH, 8'hFF);
      wr(ppn_pkg::IDX_EN_HIGH, 8'hFF);
      pulse(4'h8);
      chk(pa, 8'hA5);
      chk(pb, 8'hBF);
      wr(ppn_pkg::IDX_PORT_A, 8'h00);
      rd(ppn_pkg::IDX_PORT_A, 8'hA5);
      wr(ppn_pkg::IDX_EN_LOW, 8'h0F);
      wr(ppn_pkg::IDX_NEXT_LOW, 8'h5A);
      wr(ppn_pkg::IDX_EN_HIGH, 8'h00);
      wr(ppn_pkg::IDX_NEXT_HIGH, 8'h00);
      pulse(4'h8);
      chk(pa, 8'hAA);
      chk(pb, 8'hBF);
      wr(ppn_pkg::IDX_PORT_B, 8'h12);
      rd(ppn_pkg::IDX_PORT_B, 8'h12);
   endtask : t_shared
   // Split triggers: group 0 on channel 0, group 2 on channel 1
   task automatic t_split;
      wr(ppn_pkg::IDX_EN_LOW, 8'hFF);
      wr(ppn_pkg::IDX_EN_HIGH, 8'hFF);
      wr(ppn_pkg::IDX_TRIG_SEL, 8'hDC);
      rd(ppn_pkg::IDX_TRIG_SEL, 8'hDC);
      wr(ppn_pkg::IDX_NEXT_LOW, 8'h3C);
      rd(ppn_pkg::IDX_NEXT_LOW, 8'h3F);
      wr(ppn_pkg::IDX_NEXT_G0, 8'h96);
      rd(ppn_pkg::IDX_NEXT_G0, 8'hF6);
      wr(ppn_pkg::IDX_NEXT_HIGH, 8'h7E);
      rd(ppn_pkg::IDX_NEXT_HIGH, 8'h7F);
      wr(ppn_pkg::IDX_NEXT_G2, 8'h81);
      rd(ppn_pkg::IDX_NEXT_G2, 8'hF1);
      pulse(4'h1);
      chk(pa, 8'hA6);
      pulse(4'h2);
      chk(pb, 8'h11);
      pulse(4'h8);
      chk(pa, 8'h36);
      chk(pb, 8'h31);
   endtask : t_split
   // Software standby keeps all and blocks strobes; hardware standby clears
   task automatic t_standby;
      wr(ppn_pkg::IDX_NEXT_G0, 8'h00);
      @(posedge clk);
      sw <= 1'b1;
      pulse(4'hF);
      chk(pa, 8'h36);
      rd(ppn_pkg::IDX_NEXT_G0, 8'hF0);
      sw <= 1'b0;
      @(posedge clk);
      hw <= 1'b1;
      @(posedge clk);
      hw <= 1'b0;
      rd(ppn_pkg::IDX_NEXT_LOW, 8'h00);
      rd(ppn_pkg::IDX_NEXT_HIGH, 8'h00);
      rd(ppn_pkg::IDX_EN_LOW, 8'h00);
      rd(ppn_pkg::IDX_EN_HIGH, 8'h00);
      rd(ppn_pkg::IDX_TRIG_SEL, 8'hFF);
      chk(pa, 8'h00);
   endtask : t_standby
   // Write and strobe on one edge: the old byte goes out, the new one stays
   task automatic t_coincide;
      logic [7:0] q;
      wr(ppn_pkg::IDX_EN_LOW, 8'hFF);
      wr(ppn_pkg::IDX_NEXT_LOW, 8'h11);
      bus(ppn_pkg::IDX_NEXT_LOW, 1'b1, 8'h22, 4'h8, q);
      #1;
      chk(pa, 8'h11);
      pulse(4'h8);
      chk(pa, 8'h22);
   endtask : t_coincide
   task automatic print_verdict;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_shared();
      t_split();
      t_standby();
      t_coincide();
      print_verdict();
   end
   // Watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      #(3000 * 100);
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end
endmodule : ppn_top_tb
